//--- timer_pkg.sv
// Constants shared by the timer slice: register map, field positions, modes and reset values.
package timer_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_EVCTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    localparam logic [7:0] OFS_COMPARE = 8'h14;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_CLKSRC_LO = 1;
    localparam int CTRL_RESTART = 4;
    localparam int CTRL_CHAIN = 5;
    localparam int MODE_SEL_LO = 0;
    localparam int MODE_OUT_EN = 4;
    localparam int MODE_INIT = 5;
    localparam int MODE_IMM = 6;
    localparam int EV_CAPTURE_EVENT_EN = 0;
    localparam int EV_EDGE = 4;
    localparam int EV_FILTER = 6;
    localparam int STATUS_RUN = 0;

    // ****************************************
    // Modes, clock sources and values
    // ****************************************
    localparam logic [2:0] MODE_PERIODIC = 3'h0;
    localparam logic [2:0] MODE_CAPTURE = 3'h2;
    localparam logic [2:0] MODE_SINGLE = 3'h6;
    localparam logic [2:0] MODE_PWM8 = 3'h7;
    localparam logic [2:0] CLK_DIV1 = 3'h0;
    localparam logic [2:0] CLK_DIV2 = 3'h1;
    localparam logic [2:0] CLK_PARTNER = 3'h2;
    localparam logic [2:0] CLK_EVENT = 3'h3;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_FLOOR = 16'h0000;
    localparam logic [15:0] RESET_COMPARE = 16'h0000;
    localparam logic [1:0] IMM_START_TICKS = 2'h2;
    localparam int FILTER_DEPTH = 4;

endpackage

//--- timer_oneshot_pwm_cascade.sv
// Timer slice: single-shot, 8-bit PWM, capture (chain bit stored but has no effect), noise filter, Wishbone registers.
`timescale 1ns/1ps
`default_nettype none

module timer_oneshot_pwm_cascade
    import timer_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic capture_event_i,
    input wire logic count_event_i,
    input wire logic partner_tick_i,
    input wire logic partner_restart_i,
    output logic waveform_o,
    output logic waveform_oe_o,
    output logic overflow_event_o
);

    // ****************************************
    // Register file
    // ****************************************
    logic ack_r, enable_r, restart_with_partner_r, chain_r, waveform_out_en_r, output_initial_level_r;
    logic immediate_trigger_sel_r, capture_input_en_r, edge_sel_r, filter_en_r, running_r;
    logic [31:0] dat_r;
    logic [2:0] clock_source_sel_r, timer_mode_sel_r;
    logic [15:0] count_r, compare_r;

    logic req, wr_hit, wr_ctrl, wr_mode, wr_ev, wr_count, wr_compare;

    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr_hit = req && wb_we_i;
    assign wr_ctrl = wr_hit && wb_sel_i[0] && (wb_adr_i == OFS_CTRL);
    assign wr_mode = wr_hit && wb_sel_i[0] && (wb_adr_i == OFS_MODE);
    assign wr_ev = wr_hit && wb_sel_i[0] && (wb_adr_i == OFS_EVCTRL);
    assign wr_count = wr_hit && (wb_adr_i == OFS_COUNT) && (wb_sel_i[1:0] != 2'h0);
    assign wr_compare = wr_hit && (wb_adr_i == OFS_COMPARE) && (wb_sel_i[1:0] != 2'h0);

    // Byte lanes keep the unselected half of a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [1:0] sel, input logic [15:0] d);
        logic [15:0] m;
        m = old;
        if (sel[0]) begin
            m[7:0] = d[7:0];
        end
        if (sel[1]) begin
            m[15:8] = d[15:8];
        end
        return m;
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h00000000;
        end else if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                OFS_CTRL: dat_r <= {26'h0, chain_r, restart_with_partner_r, clock_source_sel_r, enable_r};
                OFS_MODE: dat_r <= {25'h0, immediate_trigger_sel_r, output_initial_level_r, waveform_out_en_r,
                                    1'b0, timer_mode_sel_r};
                OFS_EVCTRL: dat_r <= {25'h0, filter_en_r, 1'b0, edge_sel_r, 3'h0, capture_input_en_r};
                OFS_STATUS: dat_r <= {31'h0, running_r};
                OFS_COUNT: dat_r <= {16'h0, count_r};
                OFS_COMPARE: dat_r <= {16'h0, compare_r};
                default: dat_r <= 32'h00000000;
            endcase
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_r <= 1'b0;
            clock_source_sel_r <= CLK_DIV1;
            restart_with_partner_r <= 1'b0;
            chain_r <= 1'b0;
            timer_mode_sel_r <= MODE_PERIODIC;
            waveform_out_en_r <= 1'b0;
            output_initial_level_r <= 1'b0;
            immediate_trigger_sel_r <= 1'b0;
            capture_input_en_r <= 1'b0;
            edge_sel_r <= 1'b0;
            filter_en_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                enable_r <= wb_dat_i[CTRL_ENABLE];
                clock_source_sel_r <= wb_dat_i[CTRL_CLKSRC_LO +: 3];
                restart_with_partner_r <= wb_dat_i[CTRL_RESTART];
                chain_r <= wb_dat_i[CTRL_CHAIN];
            end
            if (wr_mode) begin
                timer_mode_sel_r <= wb_dat_i[MODE_SEL_LO +: 3];
                waveform_out_en_r <= wb_dat_i[MODE_OUT_EN];
                output_initial_level_r <= wb_dat_i[MODE_INIT];
                immediate_trigger_sel_r <= wb_dat_i[MODE_IMM];
            end
            if (wr_ev) begin
                capture_input_en_r <= wb_dat_i[EV_CAPTURE_EVENT_EN];
                edge_sel_r <= wb_dat_i[EV_EDGE];
                filter_en_r <= wb_dat_i[EV_FILTER];
            end
        end
    end

    // ****************************************
    // Counter clock selection
    // ****************************************
    logic div2_r;
    logic tick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div2_r <= 1'b0;
        end else begin
            div2_r <= !div2_r;
        end
    end

    always_comb begin
        unique case (clock_source_sel_r)
            CLK_DIV1: tick = 1'b1;
            CLK_DIV2: tick = div2_r;
            CLK_PARTNER: tick = partner_tick_i;
            CLK_EVENT: tick = count_event_i;
            default: tick = 1'b0;
        endcase
    end

    // ****************************************
    // Event input filter and edge detection
    // ****************************************
    logic [FILTER_DEPTH-1:0] samp_r;
    logic filt_level_r, event_q_r, lvl_prev_r, lvl, trig, raw_trig;

    // The filter runs on the undivided clock so the prescaler never stretches it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            samp_r <= '0;
            filt_level_r <= 1'b0;
        end else begin
            samp_r <= {samp_r[FILTER_DEPTH-2:0], capture_event_i};
            if ((&samp_r) || !(|samp_r)) begin
                filt_level_r <= samp_r[0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_q_r <= 1'b0;
            lvl_prev_r <= 1'b0;
        end else begin
            event_q_r <= capture_event_i;
            lvl_prev_r <= lvl;
        end
    end

    assign lvl = filter_en_r ? filt_level_r : event_q_r;
    assign trig = capture_input_en_r && (edge_sel_r ? (lvl ^ lvl_prev_r) : (lvl && !lvl_prev_r));
    // The immediate path looks at the raw pin so the output can rise in the event's own cycle.
    assign raw_trig = capture_input_en_r &&
                      (edge_sel_r ? (capture_event_i ^ event_q_r) : (capture_event_i && !event_q_r));

    // ****************************************
    // Counter and single-shot sequencing
    // ****************************************
    logic ss_mode, pwm_mode, enable_prev_r, edge_prev_r, self_start, cooldown_r, hold_r, ovf_r, partner_clear;
    logic [1:0] pend_r;

    assign ss_mode = enable_r && (timer_mode_sel_r == MODE_SINGLE);
    assign pwm_mode = enable_r && (timer_mode_sel_r == MODE_PWM8);
    assign partner_clear = enable_r && restart_with_partner_r && partner_restart_i;
    assign self_start = enable_r && (!enable_prev_r || (edge_sel_r != edge_prev_r));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_prev_r <= 1'b0;
            edge_prev_r <= 1'b0;
        end else begin
            enable_prev_r <= enable_r;
            edge_prev_r <= edge_sel_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_r <= COUNT_FLOOR;
            running_r <= 1'b0;
            cooldown_r <= 1'b0;
            hold_r <= 1'b0;
            pend_r <= 2'h0;
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= 1'b0;
            if (!enable_r) begin
                running_r <= 1'b0;
                cooldown_r <= 1'b0;
                hold_r <= 1'b0;
                pend_r <= 2'h0;
            end else if (ss_mode) begin
                if (tick && cooldown_r) begin
                    cooldown_r <= 1'b0;
                end
                if (running_r && tick) begin
                    if (count_r == compare_r) begin
                        running_r <= 1'b0;
                        cooldown_r <= 1'b1;
                        hold_r <= 1'b0;
                    end else begin
                        count_r <= count_r + 16'h0001;
                    end
                end else if (!running_r && !cooldown_r) begin
                    if (immediate_trigger_sel_r && (pend_r != 2'h0)) begin
                        if (tick && (pend_r == IMM_START_TICKS)) begin
                            running_r <= 1'b1;
                            count_r <= COUNT_FLOOR;
                            pend_r <= 2'h0;
                        end else if (tick) begin
                            pend_r <= pend_r + 2'h1;
                        end
                    end else if (immediate_trigger_sel_r && raw_trig) begin
                        hold_r <= 1'b1;
                        pend_r <= 2'h1;
                    end else if (!immediate_trigger_sel_r && trig) begin
                        running_r <= 1'b1;
                        count_r <= COUNT_FLOOR;
                    end else if (self_start && (count_r != compare_r)) begin
                        running_r <= 1'b1;
                    end
                end
            end else if (pwm_mode) begin
                running_r <= 1'b1;
                if (tick) begin
                    count_r <= (count_r[7:0] >= compare_r[7:0]) ? COUNT_FLOOR : count_r + 16'h0001;
                end
            end else begin
                running_r <= 1'b1;
                if (tick) begin
                    count_r <= count_r + 16'h0001;
                    ovf_r <= (count_r == COUNT_MAX);
                end
            end
            if (partner_clear) begin
                count_r <= COUNT_FLOOR;
            end
            if (wr_count) begin
                count_r <= merge16(count_r, wb_sel_i[1:0], wb_dat_i[15:0]);
            end
        end
    end

    assign overflow_event_o = ovf_r;

    // ****************************************
    // Compare register and capture
    // ****************************************
    logic cap_hit;

    assign cap_hit = enable_r && (timer_mode_sel_r == MODE_CAPTURE) && trig;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_r <= RESET_COMPARE;
        end else if (wr_compare) begin
            compare_r <= merge16(compare_r, wb_sel_i[1:0], wb_dat_i[15:0]);
        end else if (cap_hit) begin
            compare_r <= count_r;
        end
    end

    // ****************************************
    // Waveform output
    // ****************************************
    logic wave_r, ss_level, level;

    // PWM level is registered; one cycle of lag keeps the pin free of compare glitches.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wave_r <= 1'b0;
        end else if (pwm_mode) begin
            wave_r <= (count_r[7:0] < compare_r[15:8]);
        end else begin
            wave_r <= output_initial_level_r;
        end
    end

    // The immediate term is combinational from the event pin by intent.
    assign ss_level = running_r || hold_r ||
                      (immediate_trigger_sel_r && raw_trig && !cooldown_r && (pend_r == 2'h0));
    assign level = ss_mode ? ss_level : wave_r;
    assign waveform_o = waveform_out_en_r && level;
    assign waveform_oe_o = waveform_out_en_r;

    // ****************************************
    // Assertions
    // ****************************************
    a_stopped_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (ss_mode && !running_r && !hold_r && !immediate_trigger_sel_r) |-> !waveform_o)
        else $error("single-shot output high while stopped");
    a_trigger_starts: assert property (@(posedge clk_i) disable iff (rst_i)
        (ss_mode && !immediate_trigger_sel_r && trig && !running_r && !cooldown_r && !wr_count && !partner_clear)
        |=> (running_r && count_r == COUNT_FLOOR && (waveform_o == waveform_out_en_r)))
        else $error("trigger did not start counter from zero");
    a_status_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (req && !wb_we_i && wb_adr_i == OFS_STATUS) |=> (wb_ack_o && wb_dat_o[STATUS_RUN] == $past(running_r)))
        else $error("status read does not show running state");
    a_stop_compare: assert property (@(posedge clk_i) disable iff (rst_i)
        (ss_mode && running_r && tick && count_r == compare_r && !wr_ctrl && !wr_mode)
        |=> (!running_r && cooldown_r && !waveform_o))
        else $error("single-shot did not stop at compare");
    a_sync_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        (ss_mode && !immediate_trigger_sel_r && !filter_en_r && capture_input_en_r && !edge_sel_r
         && capture_event_i && !event_q_r && !running_r && !cooldown_r && !wr_hit)
        |=> ##1 running_r)
        else $error("sync single-shot not running two cycles after event");
    a_immediate_trigger_sel_now: assert property (@(posedge clk_i) disable iff (rst_i)
        (ss_mode && immediate_trigger_sel_r && raw_trig && !running_r && !cooldown_r && pend_r == 2'h0)
        |-> (waveform_o == waveform_out_en_r))
        else $error("immediate trigger did not set output");
    a_pwm_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (pwm_mode && tick && count_r[7:0] == compare_r[7:0] && !wr_count && !partner_clear && !wr_ctrl)
        |=> (count_r == COUNT_FLOOR) ##1 (wave_r == (compare_r[15:8] != 8'h00)))
        else $error("pwm counter did not wrap at period byte");
    a_out_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !waveform_out_en_r |-> (!waveform_o && !waveform_oe_o))
        else $error("waveform driven while output disabled");
    a_ovf_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        (enable_r && !ss_mode && !pwm_mode && tick && count_r == COUNT_MAX && !wr_count && !wr_ctrl && !wr_mode)
        |=> (overflow_event_o && count_r == COUNT_FLOOR) ##1 !overflow_event_o)
        else $error("overflow event missing at all-ones");
    a_capture_copy: assert property (@(posedge clk_i) disable iff (rst_i)
        (cap_hit && !wr_compare) |=> (compare_r == $past(count_r)))
        else $error("capture did not copy count");
    a_filter_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        (filt_level_r != $past(filt_level_r)) |-> ($past(samp_r) == {FILTER_DEPTH{filt_level_r}}))
        else $error("filter passed an unstable level");
    a_partner_restart: assert property (@(posedge clk_i) disable iff (rst_i)
        (partner_clear && !wr_count) |=> (count_r == COUNT_FLOOR))
        else $error("counter not cleared on partner restart");

endmodule

`default_nettype wire

//--- event_partner_model.sv
// Model of the event routing network and type-A timer feeding the timer slice.
`timescale 1ns/1ps
`default_nettype none

module event_partner_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic level_i,
    input wire logic restart_req_i,
    output logic capture_event_o,
    output logic partner_tick_o,
    output logic partner_restart_o
);
    // The bench holds level_i for many cycles, so every event lasts well over one clock.
    assign capture_event_o = level_i;
    assign partner_restart_o = restart_req_i;

    // ****************************************
    // Type-A timer ticks at half the clock rate
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            partner_tick_o <= 1'b0;
        end else begin
            partner_tick_o <= ~partner_tick_o;
        end
    end
endmodule
`default_nettype wire

//--- timer_oneshot_pwm_cascade_bench.sv
// Self-checking bench for the timer slice.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fail_count++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end

module timer_oneshot_pwm_cascade_bench;
    import timer_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic ack, cap_ev, p_tick, p_rst, wave, wave_oe, ovf, seen;
    logic cnt_ev = 1'b0;
    logic ev_lvl = 1'b0;
    logic rst_req = 1'b0;
    int fail_count = 0;
    int compares = 0;
    int n;

    always #20 clk_i = ~clk_i;

    event_partner_model event_partner_model_inst (.clk_i(clk_i), .rst_i(rst_i), .level_i(ev_lvl),
        .restart_req_i(rst_req), .capture_event_o(cap_ev), .partner_tick_o(p_tick), .partner_restart_o(p_rst));

    timer_oneshot_pwm_cascade timer_oneshot_pwm_cascade_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .capture_event_i(cap_ev), .count_event_i(cnt_ev), .partner_tick_i(p_tick),
        .partner_restart_i(p_rst), .waveform_o(wave), .waveform_oe_o(wave_oe), .overflow_event_o(ovf));

    // ****************************************
    // Bus cycles and helpers
    // ****************************************
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && t < 20) begin
            @(posedge clk_i);
            t++;
        end
        if (ack !== 1'b1) begin
            fail_count++;
            $display("unexpected ack expected 1 seen %b", ack);
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHECK(nm, e, rd)
    endtask

    // Returns at the first edge where the pulse has ended, bounded so a stuck output cannot hang.
    task automatic wait_low();
        int t;
        t = 0;
        @(posedge clk_i);
        while (wave !== 1'b0 && t < 200) begin
            @(posedge clk_i);
            t++;
        end
        if (wave !== 1'b0) begin
            fail_count++;
            $display("unexpected pulse end expected 0 seen %b", wave);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(40 * 20000);
        fail_count++;
        give_verdict();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rchk("ctrl", OFS_CTRL, 32'h0);
        rchk("compare", OFS_COMPARE, 32'h0);
        rchk("unmapped", 8'h3C, 32'h0);
        wr(OFS_COMPARE, 32'h20);
        wr(OFS_COUNT, 32'h20);
        wr(OFS_MODE, 32'h16);
        wr(OFS_EVCTRL, 32'h01);
        wr(OFS_CTRL, 32'h01);
        `CHECK("oe", 1'b1, wave_oe)
        `CHECK("idle wave", 1'b0, wave)
        rchk("status idle", OFS_STATUS, 32'h0);
        ev_lvl <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHECK("early wave", 1'b0, wave)
        repeat (2) @(posedge clk_i);
        `CHECK("shot wave", 1'b1, wave)
        rchk("status run", OFS_STATUS, 32'h1);
        wait_low();
        rchk("stop count", OFS_COUNT, 32'h20);
        rchk("status stop", OFS_STATUS, 32'h0);
        ev_lvl <= 1'b0;
        repeat (5) @(posedge clk_i);
        `CHECK("fall ignored", 1'b0, wave)
        wr(OFS_EVCTRL, 32'h41);
        ev_lvl <= 1'b1;
        repeat (6) @(posedge clk_i);
        `CHECK("filter early", 1'b0, wave)
        @(posedge clk_i);
        `CHECK("filter wave", 1'b1, wave)
        wait_low();
        ev_lvl <= 1'b0;
        wr(OFS_CTRL, 32'h00);
        wr(OFS_MODE, 32'h56);
        wr(OFS_EVCTRL, 32'h11);
        wr(OFS_CTRL, 32'h01);
        `CHECK("no free start", 1'b0, wave)
        ev_lvl <= 1'b1;
        #1 `CHECK("imm rise", 1'b1, wave)
        wait_low();
        ev_lvl <= 1'b0;
        #1 `CHECK("imm fall", 1'b1, wave)
        wait_low();
        wr(OFS_CTRL, 32'h00);
        wr(OFS_COUNT, 32'h00);
        wr(OFS_CTRL, 32'h01);
        rchk("free start", OFS_STATUS, 32'h1);
        wait_low();
        wr(OFS_CTRL, 32'h00);
        wr(OFS_MODE, 32'h17);
        wr(OFS_COMPARE, 32'h0307);
        wr(OFS_COUNT, 32'h00);
        wr(OFS_CTRL, 32'h01);
        repeat (20) @(posedge clk_i);
        n = 0;
        repeat (16) begin
            @(posedge clk_i);
            n += (wave === 1'b1) ? 1 : 0;
        end
        `CHECK("pwm high", 6, n)
        wr(OFS_CTRL, 32'h00);
        wr(OFS_MODE, 32'h30);
        `CHECK("init high", 1'b1, wave)
        wr(OFS_MODE, 32'h02);
        `CHECK("oe off", 1'b0, wave_oe)
        wr(OFS_EVCTRL, 32'h00);
        wr(OFS_CTRL, 32'h27);
        wr(OFS_COUNT, 32'h1234);
        ev_lvl <= 1'b1;
        repeat (8) @(posedge clk_i);
        rchk("capture_event off", OFS_COMPARE, 32'h0307);
        ev_lvl <= 1'b0;
        wr(OFS_EVCTRL, 32'h01);
        ev_lvl <= 1'b1;
        repeat (8) @(posedge clk_i);
        rchk("capture", OFS_COMPARE, 32'h1234);
        wr(OFS_COUNT, 32'hFFFF);
        cnt_ev <= 1'b1;
        @(posedge clk_i);
        cnt_ev <= 1'b0;
        seen = 1'b0;
        repeat (3) begin
            @(posedge clk_i);
            seen = seen | (ovf === 1'b1);
        end
        `CHECK("overflow", 1'b1, seen)
        rchk("wrap", OFS_COUNT, 32'h0);
        wr(OFS_CTRL, 32'h15);
        wr(OFS_COUNT, 32'h0800);
        rst_req <= 1'b1;
        @(posedge clk_i);
        rst_req <= 1'b0;
        xfer(1'b0, OFS_COUNT, 32'h0);
        `CHECK("restart", 1'b1, rd[15:0] < 16'h0008)
        n = rd[15:0];
        repeat (16) @(posedge clk_i);
        xfer(1'b0, OFS_COUNT, 32'h0);
        `CHECK("partner rate", 1'b1, (rd[15:0] - n[15:0] == 16'h0009) || (rd[15:0] - n[15:0] == 16'h000A))
        give_verdict();
    end
endmodule
`default_nettype wire
